// File: src/ieb_bank.sv
`timescale 1ns/1ps
module ieb_bank (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// peripheral request pulses, same clock
	input wire ieb_pkg::ieb_src_s src_req,
	// forwarded requests and summary line
	output ieb_pkg::ieb_src_s fwd_req,
	output logic irq
);
	import ieb_pkg::*;

	ieb_src_s en_q, en_d; // enable words
	ieb_src_s flg_q, flg_d; // sticky request flags
	logic [2:0] prio_q [IEB_NSRC]; // per-source priority
	logic [2:0] prio_d [IEB_NSRC];
	logic [47:0] impl; // implemented-bit mask
	logic [47:0] prio_nz; // sources with nonzero priority
	logic [47:0] live; // flagged, enabled and prioritised
	logic [47:0] clr; // write-one-to-clear bits
	logic wr_pend_q; // write data phase pending
	logic [7:0] wa_q; // captured write offset
	logic rd_take; // read address phase accepted
	logic [31:0] rd_val; // read mux result
	ieb_src_s fwd_q; // forwarded request flops
	logic irq_q; // summary interrupt flop
	logic hreadyout_q; // ready flop
	logic [31:0] hrdata_q; // read data flop
	logic hresp_q; // response flop
	logic en_wr_seen_q; // helper: any enable write since reset
	logic [31:0] hsize_unused; // size is always a word here

	assign impl = {IEB_W3_IMPL, IEB_W2_IMPL, IEB_W1_IMPL};
	assign hsize_unused = {29'h0, hsize};

	// outputs straight from flops
	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;
	assign fwd_req = fwd_q;
	assign irq = irq_q;

	// address phase capture for writes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wa_q <= 8'h00;
		end else if (hready) begin
			wr_pend_q <= hsel & htrans[1] & hwrite;
			wa_q <= haddr[7:0];
		end
	end

	// read accepted in this address phase
	assign rd_take = hready & hsel & htrans[1] & ~hwrite;

	// nonzero priority per source
	always_comb begin
		for (int i = 0; i < IEB_NSRC; i++) begin
			prio_nz[i] = (prio_q[i] != IEB_PRI_OFF);
		end
	end

	// next enable words; unimplemented bits masked away
	always_comb begin
		en_d = en_q;
		if (wr_pend_q) begin
			case (wa_q)
				IEB_EN1_OFF: en_d.w1 = ieb_w1_s'(hwdata[15:0] & IEB_W1_IMPL);
				IEB_EN2_OFF: en_d.w2 = ieb_w2_s'(hwdata[15:0] & IEB_W2_IMPL);
				IEB_EN3_OFF: en_d.w3 = ieb_w3_s'(hwdata[15:0] & IEB_W3_IMPL);
				default: en_d = en_q;
			endcase
		end
	end

	// write-one-to-clear pattern for the flags
	always_comb begin
		clr = 48'h0;
		if (wr_pend_q) begin
			case (wa_q)
				IEB_FLG1_OFF: clr[15:0] = hwdata[15:0];
				IEB_FLG2_OFF: clr[31:16] = hwdata[15:0];
				IEB_FLG3_OFF: clr[47:32] = hwdata[15:0];
				default: clr = 48'h0;
			endcase
		end
	end

	// flags: a request in the clearing cycle wins over the clear
	assign flg_d = ieb_src_s'(((flg_q & ~clr) | src_req) & impl);

	// next priority fields
	always_comb begin
		for (int i = 0; i < IEB_NSRC; i++) begin
			prio_d[i] = prio_q[i];
		end
		if (wr_pend_q) begin
			for (int p = 0; p < IEB_PRI_REGS; p++) begin
				if (wa_q == 8'(IEB_PRI_BASE + 4 * p)) begin
					for (int k = 0; k < IEB_PRI_PER_REG; k++) begin
						prio_d[p * IEB_PRI_PER_REG + k] = hwdata[k * IEB_PRI_STRIDE +: 3];
					end
				end
			end
		end
	end

	// register update: enables and flags
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_q <= ieb_src_s'({IEB_EN_RST, IEB_EN_RST, IEB_EN_RST});
			flg_q <= ieb_src_s'({IEB_FLG_RST, IEB_FLG_RST, IEB_FLG_RST});
		end else begin
			en_q <= en_d;
			flg_q <= flg_d;
		end
	end

	// register update: priorities
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < IEB_NSRC; i++) begin
				prio_q[i] <= IEB_PRI_RST;
			end
		end else begin
			for (int i = 0; i < IEB_NSRC; i++) begin
				prio_q[i] <= prio_d[i];
			end
		end
	end

	// read mux over next values so a read right after a write sees it
	always_comb begin
		rd_val = IEB_RD_ZERO;
		case (haddr[7:0])
			IEB_EN1_OFF: rd_val = {16'h0, en_d.w1};
			IEB_EN2_OFF: rd_val = {16'h0, en_d.w2};
			IEB_EN3_OFF: rd_val = {16'h0, en_d.w3};
			IEB_FLG1_OFF: rd_val = {16'h0, flg_d.w1};
			IEB_FLG2_OFF: rd_val = {16'h0, flg_d.w2};
			IEB_FLG3_OFF: rd_val = {16'h0, flg_d.w3};
			default: begin
				for (int p = 0; p < IEB_PRI_REGS; p++) begin
					if (haddr[7:0] == 8'(IEB_PRI_BASE + 4 * p)) begin
						for (int k = 0; k < IEB_PRI_PER_REG; k++) begin
							rd_val[k * IEB_PRI_STRIDE +: 3] = prio_d[p * IEB_PRI_PER_REG + k];
						end
					end
				end
			end
		endcase
	end

	// bus answer: zero wait, always okay, unmapped reads zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout_q <= 1'b1;
			hresp_q <= IEB_HRESP_OKAY;
			hrdata_q <= IEB_RD_ZERO;
		end else begin
			hreadyout_q <= 1'b1;
			hresp_q <= IEB_HRESP_OKAY;
			if (rd_take) begin
				hrdata_q <= rd_val;
			end
		end
	end

	// gate flags with enable and priority
	assign live = flg_q & en_q & prio_nz;

	// forwarded requests and level interrupt
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fwd_q <= ieb_src_s'(48'h0);
			irq_q <= 1'b0;
		end else begin
			fwd_q <= ieb_src_s'(live);
			irq_q <= |live;
		end
	end

	// helper: marks the first enable write after reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			en_wr_seen_q <= 1'b0;
		end else if (wr_pend_q && (wa_q == IEB_EN1_OFF || wa_q == IEB_EN2_OFF || wa_q == IEB_EN3_OFF)) begin
			en_wr_seen_q <= 1'b1;
		end
	end

	// a cleared enable blocks forwarding next cycle
	fwd_block_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(en_q == '0) |=> (fwd_q == '0) && !irq_q)
		else $error("request forwarded with enables clear");

	// with every priority nonzero, forwarded set equals flags that were enabled
	fwd_match_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(prio_nz == '1) |=> (fwd_q == ($past(flg_q) & $past(en_q))))
		else $error("forwarded requests differ from enabled flags");

	// unimplemented bits and the upper half read back as zero, per enable word
	unimpl_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_take && (haddr[7:0] == IEB_EN2_OFF || haddr[7:0] == IEB_EN3_OFF || haddr[7:0] == IEB_EN1_OFF)
		|=> (hrdata_q[31:16] == 16'h0000)
		&& (($past(haddr[7:0]) != IEB_EN1_OFF) || ((hrdata_q[15:0] & ~IEB_W1_IMPL) == 16'h0000))
		&& (($past(haddr[7:0]) != IEB_EN2_OFF) || ((hrdata_q[15:0] & ~IEB_W2_IMPL) == 16'h0000))
		&& (($past(haddr[7:0]) != IEB_EN3_OFF) || ((hrdata_q[15:0] & ~IEB_W3_IMPL) == 16'h0000)))
		else $error("unimplemented bit read as one");

	// enables stay zero until software writes one
	reset_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!en_wr_seen_q |-> (en_q == '0))
		else $error("enable set without a write");

	// a write to word two lands masked
	word_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_q && (wa_q == IEB_EN2_OFF) |=> (en_q.w2 == ieb_w2_s'($past(hwdata[15:0]) & IEB_W2_IMPL)))
		else $error("enable word two not written");

	// a request sets its flag on the next edge
	flag_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
		((src_req & impl) != '0) |=> ((flg_q & $past(src_req & impl)) == $past(src_req & impl)))
		else $error("request did not set its flag");

	// flags hold while nothing clears them
	flag_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!(wr_pend_q && (wa_q == IEB_FLG1_OFF || wa_q == IEB_FLG2_OFF || wa_q == IEB_FLG3_OFF))
		|=> ((flg_q & $past(flg_q)) == $past(flg_q)))
		else $error("flag dropped without a clear");

	// zero priority never forwards
	prio_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> ((fwd_q & ~$past(prio_nz)) == '0))
		else $error("zero priority source forwarded");

	// unimplemented positions never hold a one
	unimpl_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		((en_q & ~impl) == '0) && ((flg_q & ~impl) == '0))
		else $error("unimplemented bit holds a one");

	// interrupt line follows the forwarded set
	irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
		irq_q == (fwd_q != '0))
		else $error("interrupt line disagrees with forwarded set");

	// a one written to flag word one clears it unless a request lands too
	flag_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_q && (wa_q == IEB_FLG1_OFF)
		|=> ((flg_q.w1 & $past(hwdata[15:0]) & ~$past(src_req.w1)) == 16'h0000))
		else $error("flag not cleared by a written one");

	// enables change only through an enable write
	en_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		!(wr_pend_q && (wa_q == IEB_EN1_OFF || wa_q == IEB_EN2_OFF || wa_q == IEB_EN3_OFF))
		|=> (en_q == $past(en_q)))
		else $error("enable changed without a write");

	// a priority write decides which sources count as disabled
	prio_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_pend_q && (wa_q == IEB_PRI_BASE)
		|=> (prio_nz[0] == ($past(hwdata[2:0]) != IEB_PRI_OFF))
		&& (prio_nz[7] == ($past(hwdata[7 * IEB_PRI_STRIDE +: 3]) != IEB_PRI_OFF)))
		else $error("priority field write not applied");

	// an enabled request raises the interrupt line two edges later
	irq_rise_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(((src_req & en_q & prio_nz & impl) != '0) && !wr_pend_q) |-> ##2 irq_q)
		else $error("enabled request did not raise the interrupt");

	// nothing is forwarded without its flag
	fwd_flag_a: assert property (@(posedge hclk) disable iff (!hresetn)
		1'b1 |=> ((fwd_q & ~$past(flg_q)) == '0))
		else $error("request forwarded without its flag");

	// reading word one returns the stored enables
	rd_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
		rd_take && (haddr[7:0] == IEB_EN1_OFF) && !wr_pend_q |=> (hrdata_q[15:0] == $past(en_q.w1)))
		else $error("enable word one read back wrong");
endmodule

// File: src/ieb_pkg.sv
package ieb_pkg;
	// register byte offsets inside the block
	localparam logic [7:0] IEB_EN1_OFF = 8'h00;
	localparam logic [7:0] IEB_EN2_OFF = 8'h04;
	localparam logic [7:0] IEB_EN3_OFF = 8'h08;
	localparam logic [7:0] IEB_FLG1_OFF = 8'h0C;
	localparam logic [7:0] IEB_FLG2_OFF = 8'h10;
	localparam logic [7:0] IEB_FLG3_OFF = 8'h14;
	localparam logic [7:0] IEB_PRI_BASE = 8'h18;
	// priority registers: six words, eight 3-bit fields each at a 4-bit stride
	localparam int IEB_PRI_REGS = 6;
	localparam int IEB_PRI_PER_REG = 8;
	localparam int IEB_PRI_STRIDE = 4;
	localparam int IEB_NSRC = 48;
	localparam logic [2:0] IEB_PRI_RST = 3'h4;
	localparam logic [2:0] IEB_PRI_OFF = 3'h0;
	// implemented bits of each word (unimplemented: word1 bit 2, word2 bit 13, word3 bit 14)
	localparam logic [15:0] IEB_W1_IMPL = 16'hFFFB;
	localparam logic [15:0] IEB_W2_IMPL = 16'hDFFF;
	localparam logic [15:0] IEB_W3_IMPL = 16'hBFFF;
	localparam logic [15:0] IEB_EN_RST = 16'h0000;
	localparam logic [15:0] IEB_FLG_RST = 16'h0000;
	localparam logic [31:0] IEB_RD_ZERO = 32'h0000_0000;
	// ahb-lite encodings
	localparam logic [1:0] IEB_HTRANS_IDLE = 2'h0;
	localparam logic IEB_HRESP_OKAY = 1'b0;

	// first enable word
	typedef struct packed {
		logic [11:0] upper_srcs_en;
		logic change_notify_en;
		logic unused2;
		logic i2c_ch1_master_en;
		logic i2c_ch1_slave_en;
	} ieb_w1_s;

	// second enable word
	typedef struct packed {
		logic timer_six_en;
		logic dma_ch4_done_en;
		logic unused13;
		logic out_cmp_ch8_en;
		logic out_cmp_ch7_en;
		logic out_cmp_ch6_en;
		logic out_cmp_ch5_en;
		logic in_cap_ch6_en;
		logic in_cap_ch5_en;
		logic in_cap_ch4_en;
		logic in_cap_ch3_en;
		logic dma_ch3_done_en;
		logic can_one_event_en;
		logic can_one_rx_ready_en;
		logic spi_two_event_en;
		logic spi_two_error_en;
	} ieb_w2_s;

	// third enable word
	typedef struct packed {
		logic pwm_fault_a_en;
		logic unused14;
		logic dma_ch5_done_en;
		logic codec_iface_event_en;
		logic codec_iface_error_en;
		logic quad_encoder_event_en;
		logic pwm_error_en;
		logic can_two_event_en;
		logic can_two_rx_ready_en;
		logic ext_irq_four_en;
		logic ext_irq_three_en;
		logic timer_nine_en;
		logic timer_eight_en;
		logic i2c_ch2_master_en;
		logic i2c_ch2_slave_en;
		logic timer_seven_en;
	} ieb_w3_s;

	// all 48 sources, one bit each, same layout for requests, flags and enables
	typedef struct packed {
		ieb_w3_s w3;
		ieb_w2_s w2;
		ieb_w1_s w1;
	} ieb_src_s;
endpackage

// File: testbench/ieb_src_model.sv
`timescale 1ns/1ps
// peripheral sources: turn a bench command into request lines, registered one cycle later
module ieb_src_model
	import ieb_pkg::*;
(
	// clock
	input wire logic hclk,
	// pulse command from the bench, same layout as the sources
	input wire logic [47:0] fire,
	// requests toward the bank
	output ieb_pkg::ieb_src_s src_req
);
	// each request follows the bench command one cycle later and lasts as long as the command is held
	always_ff @(posedge hclk) begin
		src_req <= ieb_src_s'(fire);
	end
endmodule

// File: testbench/interrupt_enable_bank_tb.sv
`timescale 1ns/1ps
module interrupt_enable_bank_tb;
	import ieb_pkg::*;
	// bus side
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd_v;
	logic hreadyout, hresp, irq;
	// model state: enables, sticky flags, zero-priority sources
	logic [47:0] fire = 0, en_m = 0, flg_m = 0, pz_m = 0, impl;
	ieb_src_s src_req, fwd_req;
	int n_mismatch = 0, checks = 0;
	assign impl = {IEB_W3_IMPL, IEB_W2_IMPL, IEB_W1_IMPL};
	// 100 MHz clock
	always #5 hclk = ~hclk;
	ieb_src_model srcs (.hclk(hclk), .fire(fire), .src_req(src_req));
	ieb_bank dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .src_req(src_req), .fwd_req(fwd_req), .irq(irq));
	// compare and count
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// single word transfer: address phase, then data phase, each held until hready
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= IEB_HTRANS_IDLE;
		hsel <= 1'b0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_v = hrdata;
		chk({47'h0, hresp}, {47'h0, IEB_HRESP_OKAY});
	endtask
	// write an enable word and read it back
	task automatic set_en(input int w, input logic [15:0] d);
		xfer(1'b1, IEB_EN1_OFF + 8'(4 * w), {16'h0, d});
		en_m[16 * w +: 16] = d & impl[16 * w +: 16];
		xfer(1'b0, IEB_EN1_OFF + 8'(4 * w), 32'h0);
		chk({16'h0, rd_v}, {32'h0, en_m[16 * w +: 16]});
	endtask
	// fire sources, then compare forwarded requests after the flag stage
	task automatic pulse(input logic [47:0] m);
		@(posedge hclk);
		fire <= m;
		@(posedge hclk);
		fire <= '0;
		flg_m = flg_m | (m & impl);
		repeat (3) @(posedge hclk);
		#1;
		chk(fwd_req, flg_m & en_m & ~pz_m);
		chk({47'h0, irq}, {47'h0, |(flg_m & en_m & ~pz_m)});
	endtask
	// clear all flags by writing ones, then read them back
	task automatic clr_flags();
		for (int w = 0; w < 3; w++) begin
			xfer(1'b1, IEB_FLG1_OFF + 8'(4 * w), 32'h0000_FFFF);
			xfer(1'b0, IEB_FLG1_OFF + 8'(4 * w), 32'h0);
			chk({16'h0, rd_v}, 48'h0);
		end
		flg_m = '0;
	endtask
	// clear all flags, then fire a single source
	task automatic one_src(input int b);
		clr_flags();
		pulse(48'h1 << b);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		test_done();
	end
	initial begin
		void'($urandom(24699));
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		#1;
		chk({47'h0, hreadyout}, 48'h1);
		// enable and flag words start at zero
		for (int w = 0; w < 6; w++) begin
			xfer(1'b0, IEB_EN1_OFF + 8'(4 * w), 32'h0);
			chk({16'h0, rd_v}, 48'h0);
		end
		// random values, then all ones: holes stay zero
		for (int i = 0; i < 9; i++) set_en(i % 3, 16'($urandom));
		for (int w = 0; w < 3; w++) set_en(w, 16'hFFFF);
		// walk each source in turn through its own enable bit; flags are not cleared between pulses
		for (int b = 0; b < 48; b++) pulse(48'h1 << b);
		// flag word two reads the sticky requests, hole zero
		xfer(1'b0, IEB_FLG2_OFF, 32'h0);
		chk({16'h0, rd_v}, {32'h0, IEB_W2_IMPL});
		// every enable cleared: flags stay set, nothing forwarded
		for (int w = 0; w < 3; w++) set_en(w, 16'h0000);
		pulse(48'h0);
		for (int w = 0; w < 3; w++) set_en(w, 16'hFFFF);
		// each named field lights alone from the bit its rule gives
		one_src(31);
		chk({47'h0, fwd_req.w2.timer_six_en}, 48'h1);
		one_src(47);
		chk({47'h0, fwd_req.w3.pwm_fault_a_en}, 48'h1);
		one_src(3);
		chk({47'h0, fwd_req.w1.change_notify_en}, 48'h1);
		one_src(16);
		chk({47'h0, fwd_req.w2.spi_two_error_en}, 48'h1);
		one_src(32);
		chk({47'h0, fwd_req.w3.timer_seven_en}, 48'h1);
		clr_flags();
		pulse(48'h0);
		// priority zero on sources 0..7 blocks them despite enable
		xfer(1'b1, IEB_PRI_BASE, 32'h0);
		pz_m[7:0] = 8'hFF;
		pulse('1);
		clr_flags();
		// top priority on sources 0..7 lets them through again
		xfer(1'b1, IEB_PRI_BASE, 32'h7777_7777);
		pz_m[7:0] = 8'h00;
		pulse('1);
		clr_flags();
		// random enables and requests, masking on and off
		for (int i = 0; i < 20; i++) begin
			set_en(i % 3, 16'($urandom));
			pulse({16'($urandom), 16'($urandom), 16'($urandom)});
			if (i % 5 == 4) clr_flags();
		end
		// unmapped offset reads zero
		xfer(1'b0, 8'hFC, 32'h0);
		chk({16'h0, rd_v}, 48'h0);
		test_done();
	end
endmodule
